// ### verilog/eas_top.sv
// Extra area flash sequencer with AXI4-Lite register slave
`timescale 1ns/1ns

module eas_top #(
   parameter int PROG_CYCLES = eas_pkg::PROG_CYCLES
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             boot_cluster_sel_q,
   output logic             window_shield_mode_q,
   output logic             serial_write_protect_q
);

   typedef enum logic [1:0] {
      SEQ_IDLE,
      SEQ_PROG,
      SEQ_DONE
   } eas_seq_t;

   // ------------------------------------------------------------
   // Register storage
   // ------------------------------------------------------------
   logic [7:0]              ctrl_q;
   logic [15:0]             wbuf_hi_q;
   logic [15:0]             wbuf_lo_q;
   logic                    area_sel_q;
   eas_pkg::eas_mode_t      mode_q;
   logic [31:0]             win_word_q;
   logic [31:0]             rdp_word_q;
   logic [31:0]             sec_word_q;
   logic                    swap_ovr_q;
   logic                    swap_sel_q;
   logic                    extra_done_q;
   logic                    extra_err_q;
   eas_seq_t                seq_q;
   logic [15:0]             prog_cnt_q;
   logic [3:0]              cmd_q;
   logic                    aw_held_q;
   logic                    w_held_q;
   logic [7:0]              aw_addr_q;
   logic [31:0]             w_data_q;
   logic [3:0]              w_strb_q;

   logic                    wr_fire;
   logic [31:0]             word_in;
   logic                    start_edge;
   logic                    cmd_ok;
   logic                    cmd_legal;
   logic [31:0]             sec_next;
   logic [31:0]             ctrl_merge;
   logic [31:0]             wbuf_hi_merge;
   logic [31:0]             wbuf_lo_merge;

   // Byte-lane merge, used for the control and write buffer registers
   function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return r;
   endfunction

   // ------------------------------------------------------------
   // AXI4-Lite write channel
   // ------------------------------------------------------------
   // Address and data are caught independently, so either may come first
   assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q     <= 1'b0;
         w_held_q      <= 1'b0;
         aw_addr_q     <= 8'h00;
         w_data_q      <= 32'h0000_0000;
         w_strb_q      <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= eas_pkg::RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_held_q && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= !w_held_q && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_held_q    <= 1'b0;
            w_held_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr_q > eas_pkg::OFF_SWAP || aw_addr_q[1:0] != 2'b00)
                            ? eas_pkg::RESP_SLVERR : eas_pkg::RESP_OKAY;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // Software registers
   // ------------------------------------------------------------
   assign word_in = {wbuf_hi_q, wbuf_lo_q};
   assign ctrl_merge    = lane_merge({24'h0, ctrl_q}, w_data_q, w_strb_q);
   assign wbuf_hi_merge = lane_merge({16'h0, wbuf_hi_q}, w_data_q, w_strb_q);
   assign wbuf_lo_merge = lane_merge({16'h0, wbuf_lo_q}, w_data_q, w_strb_q);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q     <= 8'h00;
         wbuf_hi_q  <= 16'h0000;
         wbuf_lo_q  <= 16'h0000;
         area_sel_q <= 1'b0;
         mode_q     <= eas_pkg::EAS_MODE_NONPROG;
         swap_ovr_q <= 1'b0;
         swap_sel_q <= 1'b0;
      end else if (wr_fire) begin
         unique case (aw_addr_q)
            eas_pkg::OFF_CTRL: begin
               // Bits 6..4 are read-only zero
               ctrl_q <= ctrl_merge[7:0] & 8'h8F;
            end
            eas_pkg::OFF_WBUF_HI: wbuf_hi_q <= wbuf_hi_merge[15:0];
            eas_pkg::OFF_WBUF_LO: wbuf_lo_q <= wbuf_lo_merge[15:0];
            eas_pkg::OFF_AREA_SEL: begin
               if (w_strb_q[0]) area_sel_q <= w_data_q[eas_pkg::AREA_EXTRA_BIT];
            end
            eas_pkg::OFF_MODE: begin
               if (w_strb_q[0] && w_data_q[1:0] != 2'b11) begin
                  mode_q <= eas_pkg::eas_mode_t'(w_data_q[1:0]);
               end
            end
            eas_pkg::OFF_SWAP: begin
               // Override only writable in a programming mode with boot area open
               if (w_strb_q[0] && sec_word_q[eas_pkg::SEC_BOOT_PROT] &&
                   mode_q != eas_pkg::EAS_MODE_NONPROG) begin
                  swap_ovr_q <= w_data_q[1];
                  swap_sel_q <= w_data_q[0];
               end
            end
            default: begin
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Extra area sequencer
   // ------------------------------------------------------------
   // Start in any mode; the store needs code programming mode with the extra area selected
   assign start_edge = ctrl_q[eas_pkg::CTRL_START_BIT] && seq_q == SEQ_IDLE
                       && !extra_done_q;
   assign cmd_legal  = cmd_q == eas_pkg::CMD_WIN || cmd_q == eas_pkg::CMD_RDP
                       || cmd_q == eas_pkg::CMD_SEC;
   assign cmd_ok     = cmd_legal && area_sel_q && mode_q == eas_pkg::EAS_MODE_CODE_PROG
                       && !(cmd_q == eas_pkg::CMD_WIN
                            && !win_word_q[eas_pkg::WIN_PROT_BIT])
                       && !(cmd_q == eas_pkg::CMD_RDP
                            && !rdp_word_q[eas_pkg::RDP_LOCK_BIT]);

   // Security word: flags other than the boot flag may only fall; boot flag takes the new value only while boot protect is set
   always_comb begin
      sec_next = sec_word_q & word_in;
      if (!sec_word_q[eas_pkg::SEC_BOOT_PROT]) begin
         sec_next[eas_pkg::SEC_BOOT_FLAG] = sec_word_q[eas_pkg::SEC_BOOT_FLAG];
      end else begin
         sec_next[eas_pkg::SEC_BOOT_FLAG] = word_in[eas_pkg::SEC_BOOT_FLAG];
      end
   end

   // No abort path: once running the command always reaches done
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         seq_q        <= SEQ_IDLE;
         prog_cnt_q   <= 16'h0000;
         cmd_q        <= 4'h0;
         extra_done_q <= 1'b0;
         extra_err_q  <= 1'b0;
      end else begin
         unique case (seq_q)
            SEQ_IDLE: begin
               if (start_edge) begin
                  cmd_q       <= ctrl_q[eas_pkg::CMD_MSB:0];
                  prog_cnt_q  <= 16'(PROG_CYCLES);
                  extra_err_q <= 1'b0;
                  seq_q       <= SEQ_PROG;
               end
            end
            SEQ_PROG: begin
               if (prog_cnt_q > 16'h0001) begin
                  prog_cnt_q <= prog_cnt_q - 16'h0001;
               end else begin
                  extra_done_q <= 1'b1;
                  if (!cmd_ok && cmd_legal) begin
                     extra_err_q <= 1'b1;
                  end
                  seq_q <= SEQ_DONE;
               end
            end
            SEQ_DONE: begin
               if (!ctrl_q[eas_pkg::CTRL_START_BIT]) begin
                  extra_done_q <= 1'b0;
                  seq_q        <= SEQ_IDLE;
               end
            end
            default: seq_q <= SEQ_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Extra area storage, one whole word per command
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         win_word_q <= eas_pkg::WIN_RESET;
         rdp_word_q <= eas_pkg::RDP_RESET;
         sec_word_q <= eas_pkg::SEC_RESET;
      end else if (seq_q == SEQ_PROG && prog_cnt_q <= 16'h0001 && cmd_ok) begin
         unique case (cmd_q)
            eas_pkg::CMD_WIN: win_word_q <= word_in;
            eas_pkg::CMD_RDP: rdp_word_q <= word_in;
            eas_pkg::CMD_SEC: sec_word_q <= sec_next;
            default: begin
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Outputs decoded from stored words and the swap override
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         boot_cluster_sel_q     <= 1'b0;
         window_shield_mode_q   <= 1'b1;
         serial_write_protect_q <= 1'b1;
      end else begin
         boot_cluster_sel_q     <= swap_ovr_q ? swap_sel_q
                                   : !sec_word_q[eas_pkg::SEC_BOOT_FLAG];
         window_shield_mode_q   <= win_word_q[eas_pkg::WIN_SHIELD_BIT];
         serial_write_protect_q <= sec_word_q[eas_pkg::SEC_SERIAL_WR];
      end
   end

   // ------------------------------------------------------------
   // AXI4-Lite read channel
   // ------------------------------------------------------------
   function automatic eas_pkg::eas_rd_t rd_mux(input logic [7:0] a);
      eas_pkg::eas_rd_t r;
      r.resp = eas_pkg::RESP_OKAY;
      r.data = 32'h0000_0000;
      unique case (a)
         eas_pkg::OFF_CTRL:     r.data = {24'h0, ctrl_q};
         eas_pkg::OFF_WBUF_HI:  r.data = {16'h0, wbuf_hi_q};
         eas_pkg::OFF_WBUF_LO:  r.data = {16'h0, wbuf_lo_q};
         eas_pkg::OFF_STAT_HI:  r.data = {24'h0, extra_done_q, 7'h00};
         eas_pkg::OFF_STAT_LO:  r.data = {24'h0, !sec_word_q[eas_pkg::SEC_BOOT_FLAG],
                                          1'b0, extra_err_q, 5'h00};
         eas_pkg::OFF_AREA_SEL: r.data = {31'h0, area_sel_q};
         eas_pkg::OFF_MODE:     r.data = {30'h0, mode_q};
         eas_pkg::OFF_WIN_WORD: r.data = win_word_q;
         eas_pkg::OFF_RDP_WORD: r.data = rdp_word_q;
         eas_pkg::OFF_SEC_WORD: r.data = sec_word_q;
         eas_pkg::OFF_SWAP:     r.data = {30'h0, swap_ovr_q, swap_sel_q};
         default:               r.resp = eas_pkg::RESP_SLVERR;
      endcase
      return r;
   endfunction

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= eas_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            {s_axi_rdata, s_axi_rresp} <= rd_mux(s_axi_araddr);
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   // Cycle counter kept for the timing check
   logic [15:0] run_cnt_q;
   always_ff @(posedge aclk) begin
      if (!aresetn || seq_q != SEQ_PROG) begin
         run_cnt_q <= 16'h0000;
      end else begin
         run_cnt_q <= run_cnt_q + 16'h0001;
      end
   end

   start_runs_a: assert property (@(posedge aclk) disable iff (!aresetn)
      start_edge |=> seq_q == SEQ_PROG && cmd_q == $past(ctrl_q[3:0]))
      else $error("Start did not launch the command");

   win_refused_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (seq_q == SEQ_PROG && prog_cnt_q <= 16'h0001 && cmd_q == eas_pkg::CMD_WIN
       && !win_word_q[eas_pkg::WIN_PROT_BIT]) |=> extra_err_q && $stable(win_word_q))
      else $error("Protected window write not refused");

   rdp_refused_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (seq_q == SEQ_PROG && prog_cnt_q <= 16'h0001 && cmd_q == eas_pkg::CMD_RDP
       && !rdp_word_q[eas_pkg::RDP_LOCK_BIT]) |=> extra_err_q && $stable(rdp_word_q))
      else $error("Locked read protect write not refused");

   sec_only_falls_a: assert property (@(posedge aclk) disable iff (!aresetn)
      1'b1 |-> (~$past(sec_word_q) & sec_word_q & 32'hFFFF_FEFF) == 32'h0000_0000)
      else $error("Security flag re-enabled");

   boot_flag_held_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !sec_word_q[eas_pkg::SEC_BOOT_PROT] |=> $stable(sec_word_q[eas_pkg::SEC_BOOT_FLAG]))
      else $error("Boot flag changed while protected");

   done_timing_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(extra_done_q) |-> $past(run_cnt_q) == 16'(PROG_CYCLES - 1))
      else $error("Done came at the wrong time");

   done_clears_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (extra_done_q && !ctrl_q[eas_pkg::CTRL_START_BIT]) |=> !extra_done_q)
      else $error("Done not cleared after start cleared");

   no_abort_a: assert property (@(posedge aclk) disable iff (!aresetn)
      seq_q == SEQ_PROG && prog_cnt_q > 16'h0001 |=> seq_q == SEQ_PROG)
      else $error("Running command left early");

   bad_code_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (seq_q == SEQ_PROG && !cmd_legal) |=>
         $stable(win_word_q) && $stable(rdp_word_q) && $stable(sec_word_q))
      else $error("Prohibited code modified extra area");

endmodule

// ### verilog/eas_pkg.sv
// Package for the extra area flash sequencer: register map, fields, reset values, timing
package eas_pkg;

   // ------------------------------------------------------------
   // Register byte offsets on the AXI4-Lite slave
   // ------------------------------------------------------------
   localparam logic [7:0] OFF_CTRL     = 8'h00;
   localparam logic [7:0] OFF_WBUF_HI  = 8'h04;
   localparam logic [7:0] OFF_WBUF_LO  = 8'h08;
   localparam logic [7:0] OFF_STAT_HI  = 8'h0C;
   localparam logic [7:0] OFF_STAT_LO  = 8'h10;
   localparam logic [7:0] OFF_AREA_SEL = 8'h14;
   localparam logic [7:0] OFF_MODE     = 8'h18;
   localparam logic [7:0] OFF_WIN_WORD = 8'h1C;
   localparam logic [7:0] OFF_RDP_WORD = 8'h20;
   localparam logic [7:0] OFF_SEC_WORD = 8'h24;
   localparam logic [7:0] OFF_SWAP     = 8'h28;

   // ------------------------------------------------------------
   // Control register fields
   // ------------------------------------------------------------
   localparam int CTRL_START_BIT = 7;
   localparam int CMD_MSB        = 3;

   localparam logic [3:0] CMD_WIN  = 4'h1;
   localparam logic [3:0] CMD_RDP  = 4'h6;
   localparam logic [3:0] CMD_SEC  = 4'h7;

   // Status high and low bit positions
   localparam int STH_EXTRA_DONE = 7;
   localparam int STH_MAIN_DONE  = 6;
   localparam int STL_BOOT_MON   = 7;
   localparam int STL_EXTRA_ERR  = 5;
   localparam int STL_BLANK_ERR  = 3;
   localparam int STL_WRITE_ERR  = 1;
   localparam int STL_ERASE_ERR  = 0;

   // Extra area word fields
   localparam int WIN_SHIELD_BIT  = 31;
   localparam int WIN_PROT_BIT    = 15;
   localparam int RDP_LOCK_BIT    = 31;
   localparam int SEC_SERIAL_WR   = 12;
   localparam int SEC_SERIAL_ER   = 10;
   localparam int SEC_BOOT_PROT   = 9;
   localparam int SEC_BOOT_FLAG   = 8;
   localparam int AREA_EXTRA_BIT  = 0;

   // Shipment values of the stored words
   localparam logic [31:0] WIN_RESET = 32'h8000_8000;
   localparam logic [31:0] RDP_RESET = 32'h8000_0000;
   localparam logic [31:0] SEC_RESET = 32'hFFFF_FFFF;

   // ------------------------------------------------------------
   // Programming time of one word
   // ------------------------------------------------------------
   localparam int CLK_MHZ        = 50;
   localparam int PROG_TIME_NS   = 100;
   localparam int PROG_CYCLES    = (PROG_TIME_NS * CLK_MHZ + 999) / 1000;

   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // Register bus read answer
   typedef struct packed {
      logic [31:0] data;
      logic [1:0]  resp;
   } eas_rd_t;

   // Flash sequencer mode set by software
   typedef enum logic [1:0] {
      EAS_MODE_NONPROG,
      EAS_MODE_CODE_PROG,
      EAS_MODE_DATA_PROG
   } eas_mode_t;

endpackage

// ### dv/eas_top_bench.sv
// Self-checking bench for the extra area flash sequencer
`timescale 1ns/1ns

module eas_top_bench;
   logic        aclk          = 1'b0;
   logic        aresetn       = 1'b0;
   logic [7:0]  s_axi_awaddr  = 8'h00;
   logic        s_axi_awvalid = 1'b0;
   logic        s_axi_awready;
   logic [31:0] s_axi_wdata   = 32'h0000_0000;
   logic [3:0]  s_axi_wstrb   = 4'hF;
   logic        s_axi_wvalid  = 1'b0;
   logic        s_axi_wready;
   logic [1:0]  s_axi_bresp;
   logic        s_axi_bvalid;
   logic        s_axi_bready  = 1'b0;
   logic [7:0]  s_axi_araddr  = 8'h00;
   logic        s_axi_arvalid = 1'b0;
   logic        s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0]  s_axi_rresp;
   logic        s_axi_rvalid;
   logic        s_axi_rready  = 1'b0;
   logic        boot_cluster_sel_q;
   logic        window_shield_mode_q;
   logic        serial_write_protect_q;
   int          err_total     = 0;
   int          checks_done   = 0;
   logic [31:0] rv;
   logic [1:0]  rr;

   always #10 aclk = ~aclk;

   eas_top #(.PROG_CYCLES(5)) eas_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .boot_cluster_sel_q,
      .window_shield_mode_q, .serial_write_protect_q);

   // ------------------------------------------------------------
   // Checking and closing
   // ------------------------------------------------------------
   task automatic report_and_stop;
      $display("Mismatches %0d, comparisons %0d", err_total, checks_done);
      if (err_total == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic give_up;
      err_total++;
      $display("ERROR wait limit expected answer seen none");
      report_and_stop();
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   // ------------------------------------------------------------
   // Bus cycles; first edge keeps release and new request apart
   // ------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         n++;
      end while (s_axi_bvalid !== 1'b1 && n < 40);
      rr = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (n >= 40) give_up();
   endtask

   task automatic rd(input logic [7:0] a);
      int n;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
         n++;
      end while (s_axi_rvalid !== 1'b1 && n < 40);
      rv = s_axi_rdata;
      rr = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (n >= 40) give_up();
   endtask

   task automatic poll(input logic v);
      int n;
      n = 0;
      do begin
         rd(eas_pkg::OFF_STAT_HI);
         n++;
      end while (rv[eas_pkg::STH_EXTRA_DONE] !== v && n < 40);
      if (n >= 40) give_up();
   endtask

   // Full start/done handshake; error bit read once done is seen
   task automatic cmd(input logic [3:0] code, input logic [31:0] w, input logic e);
      wr(eas_pkg::OFF_WBUF_HI, {16'h0000, w[31:16]});
      wr(eas_pkg::OFF_WBUF_LO, {16'h0000, w[15:0]});
      wr(eas_pkg::OFF_CTRL, {24'h00_0000, 4'h8, code});
      poll(1'b1);
      rd(eas_pkg::OFF_STAT_LO);
      chk("extra error", {31'h0, e}, {31'h0, rv[eas_pkg::STL_EXTRA_ERR]});
      wr(eas_pkg::OFF_CTRL, 32'h0000_0000);
      poll(1'b0);
   endtask

   initial begin
      repeat (20000) @(posedge aclk);
      give_up();
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      rd(eas_pkg::OFF_WIN_WORD);
      chk("window word", eas_pkg::WIN_RESET, rv);
      rd(eas_pkg::OFF_RDP_WORD);
      chk("read prot word", eas_pkg::RDP_RESET, rv);
      rd(eas_pkg::OFF_SEC_WORD);
      chk("security word", eas_pkg::SEC_RESET, rv);
      chk("shield out", 32'h1, {31'h0, window_shield_mode_q});
      chk("boot sel", 32'h0, {31'h0, boot_cluster_sel_q});
      wr(eas_pkg::OFF_MODE, 32'h0000_0001);
      wr(eas_pkg::OFF_AREA_SEL, 32'h0000_0001);
      cmd(eas_pkg::CMD_WIN, 32'h0012_8005, 1'b0);
      rd(eas_pkg::OFF_WIN_WORD);
      chk("window word", 32'h0012_8005, rv);
      chk("shield out", 32'h0, {31'h0, window_shield_mode_q});
      cmd(eas_pkg::CMD_WIN, 32'h8034_0006, 1'b0);
      rd(eas_pkg::OFF_WIN_WORD);
      chk("window word", 32'h8034_0006, rv);
      cmd(eas_pkg::CMD_WIN, 32'h8000_8000, 1'b1);
      rd(eas_pkg::OFF_WIN_WORD);
      chk("window word", 32'h8034_0006, rv);
      chk("shield out", 32'h1, {31'h0, window_shield_mode_q});
      cmd(eas_pkg::CMD_RDP, 32'h0020_0010, 1'b0);
      rd(eas_pkg::OFF_RDP_WORD);
      chk("read prot word", 32'h0020_0010, rv);
      cmd(eas_pkg::CMD_RDP, 32'h8000_0000, 1'b1);
      rd(eas_pkg::OFF_RDP_WORD);
      chk("read prot word", 32'h0020_0010, rv);
      cmd(eas_pkg::CMD_SEC, 32'hFFFF_FEFF, 1'b0);
      chk("boot sel", 32'h1, {31'h0, boot_cluster_sel_q});
      // Override takes the boot choice away from the stored flag
      wr(eas_pkg::OFF_SWAP, 32'h0000_0002);
      rd(eas_pkg::OFF_SWAP);
      chk("swap reg", 32'h0000_0002, rv);
      chk("boot sel", 32'h0, {31'h0, boot_cluster_sel_q});
      wr(eas_pkg::OFF_SWAP, 32'h0000_0000);
      rd(eas_pkg::OFF_STAT_LO);
      chk("boot monitor", 32'h1, {31'h0, rv[eas_pkg::STL_BOOT_MON]});
      chk("boot sel", 32'h1, {31'h0, boot_cluster_sel_q});
      cmd(eas_pkg::CMD_SEC, 32'hFFFF_ECFF, 1'b0);
      chk("serial wp", 32'h0, {31'h0, serial_write_protect_q});
      // Re-enabling is silently dropped, and the boot flag is now frozen
      cmd(eas_pkg::CMD_SEC, 32'hFFFF_FFFF, 1'b0);
      rd(eas_pkg::OFF_SEC_WORD);
      chk("security word", 32'hFFFF_ECFF, rv);
      chk("boot sel", 32'h1, {31'h0, boot_cluster_sel_q});
      // Boot area now protected: override writes are ignored
      wr(eas_pkg::OFF_SWAP, 32'h0000_0003);
      rd(eas_pkg::OFF_SWAP);
      chk("swap reg", 32'h0000_0000, rv);
      chk("boot sel", 32'h1, {31'h0, boot_cluster_sel_q});
      for (int i = 0; i < 16; i++) begin
         if (i != 1 && i != 6 && i != 7) begin
            cmd(4'(i), 32'h0000_0000, 1'b0);
            rd(eas_pkg::OFF_SEC_WORD);
            chk("security word", 32'hFFFF_ECFF, rv);
         end
      end
      wr(eas_pkg::OFF_WBUF_HI, 32'h0000_A5C3);
      rd(eas_pkg::OFF_WBUF_HI);
      chk("buffer high", 32'h0000_A5C3, rv);
      rd(8'h2C);
      chk("unmapped read", {30'h0, eas_pkg::RESP_SLVERR}, {30'h0, rr});
      wr(8'h2C, 32'h0000_0000);
      chk("unmapped write", {30'h0, eas_pkg::RESP_SLVERR}, {30'h0, rr});
      wr(eas_pkg::OFF_MODE, 32'h0000_0000);
      wr(eas_pkg::OFF_MODE, 32'h0000_0003);
      rd(eas_pkg::OFF_MODE);
      chk("mode", 32'h0000_0000, rv);
      // Outside programming mode a legal code completes with an error, no store
      cmd(eas_pkg::CMD_SEC, 32'hFFFF_E8FF, 1'b1);
      rd(eas_pkg::OFF_SEC_WORD);
      chk("security word", 32'hFFFF_ECFF, rv);
      report_and_stop();
   end
endmodule
